// *** rtl/tbmmu_pkg.sv ***
`default_nettype none
package tbmmu_pkg;
    localparam int TLB_ENTRIES = 8;
    localparam int IDX_W = 3;
    localparam int SRC_COUNT = 3;
    localparam int SRC_WALK = 0;
    localparam int SRC_DC = 1;
    localparam int SRC_IO = 2;

    localparam logic [7:0] REG_CONTEXT = 8'h00;
    localparam logic [7:0] REG_CTP = 8'h04;
    localparam logic [7:0] REG_FAULT_STAT = 8'h08;
    localparam logic [7:0] REG_FAULT_ADDR = 8'h0c;
    localparam logic [7:0] REG_TLB_SEL = 8'h10;
    localparam logic [7:0] REG_TLB_PTF = 8'h14;
    localparam logic [7:0] REG_FLUSH = 8'h18;
    localparam int FAULT_VALID_BIT = 8;

    localparam logic [1:0] ET_INVALID = 2'h0;
    localparam logic [1:0] ET_PTP = 2'h1;
    localparam logic [1:0] ET_LEAF = 2'h2;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_1 = 3'h4;
    localparam logic [2:0] LVL_2 = 3'h6;
    localparam logic [2:0] LVL_3 = 3'h7;
    localparam logic [1:0] WALK_CTX = 2'h0;
    localparam logic [1:0] WALK_LAST = 2'h3;

    // Leaf entry layout; the page table field keeps entry bits 26:2
    localparam int PTE_PTP_HI = 26;
    localparam int PTE_PTP_LO = 4;
    localparam int PTE_PPN_HI = 26;
    localparam int PTE_PPN_LO = 8;
    localparam int PTE_CACHE_BIT = 7;
    localparam int PTE_MOD_BIT = 6;
    localparam int PTE_REF_BIT = 5;
    localparam int PTE_ACC_HI = 4;
    localparam int PTE_ACC_LO = 2;
    localparam int PTF_LO = 2;
    localparam int PTF_W = 25;
    localparam logic [7:0] PTP_BASE_PAD = 8'h00;

    // Protection vector order: user R W X, supervisor R W X
    localparam int P_UR = 5;
    localparam int P_UW = 4;
    localparam int P_UX = 3;
    localparam int P_SR = 2;
    localparam int P_SW = 1;
    localparam int P_SX = 0;

    localparam logic [1:0] FLT_NONE = 2'h0;
    localparam logic [1:0] FLT_PROT = 2'h1;
    localparam logic [1:0] FLT_INVALID = 2'h2;
    localparam logic [1:0] FLT_WALK = 2'h3;

    typedef enum logic [2:0] {XL_IDLE, XL_LOOKUP, XL_WALK, XL_UPDATE} tbmmu_state_t;

    function automatic logic [5:0] decode_acc(input logic [2:0] acc);
        case (acc)
            3'h0: decode_acc = 6'h24;
            3'h1: decode_acc = 6'h36;
            3'h2: decode_acc = 6'h2d;
            3'h3: decode_acc = 6'h3f;
            3'h4: decode_acc = 6'h09;
            3'h5: decode_acc = 6'h21;
            3'h6: decode_acc = 6'h05;
            default: decode_acc = 6'h07;
        endcase
    endfunction
endpackage
`default_nettype wire

// *** rtl/tbmmu_arb_if.sv ***
`default_nettype none
interface tbmmu_arb_if;
    logic [tbmmu_pkg::SRC_COUNT-1:0] req;
    logic [tbmmu_pkg::SRC_COUNT-1:0] gnt;
    logic done;
    modport arbiter (input req, input done, output gnt);
    modport client (output req, output done, input gnt);
endinterface
`default_nettype wire

// *** rtl/tbmmu_arbiter.sv ***
`default_nettype none
module tbmmu_arbiter
(
    input wire logic sys_clk,
    input wire logic arst_n,
    tbmmu_arb_if.arbiter arb
);
    // Lowest index wins, so table walks go ahead of cache and I/O traffic
    function automatic logic [tbmmu_pkg::SRC_COUNT-1:0] pick(
        input logic [tbmmu_pkg::SRC_COUNT-1:0] r);
        pick = r & (~r + 1'b1);
    endfunction

    // Grant is held for the whole memory transfer and dropped on its completion
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            arb.gnt <= '0;
        else if (arb.done)
            arb.gnt <= '0;
        else if (arb.gnt == '0)
            arb.gnt <= pick(arb.req);
    end
endmodule
`default_nettype wire

// *** rtl/tbmmu_core.sv ***
`default_nettype none
// Behaviour
// - Translate virtual to physical addresses through the buffer, checking protection.
// - Arbitrate memory between I/O, data cache and table-walk requests.
// - Each entry keeps virtual tag bits 31:12.
// - Each entry keeps a context tag compared with the 6-bit context register.
// - Each entry keeps six decoded protection bits, user and supervisor R/W/X.
// - Level field selects tag bits: none, 31:24, 31:18, 31:12.
// - Level field top bit is the entry valid indicator.
// - Supervisor bit skips context compare on supervisor accesses.
// - Entry modified bit is set when its page is written.
// - Entry I/O indicator reads 0 when an I/O leaf is held; this design writes it as 1 on every fill.
// - Entry pointer indicator set marks a held table pointer.
// - Page table field holds the entry, readable by software as 25 bits.
// - Leaf bits 26:8 give the upper 19 physical page address bits.
// - Leaf bit 7 marks the page cacheable; others bypass caching.
// - Leaf bits 4:2 with access kind decide if access is allowed.
// - Permission code decodes per the user/supervisor permission table.
// - Entry type bits 1:0: invalid, table pointer, leaf, reserved.
// - Low 12 bits pass through; violations return a memory exception.
// - On a miss walk the tables, load the leaf, fault if none.
module tbmmu_core
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xlReq,
    input wire logic [31:0] xlVa,
    input wire logic xlWrite,
    input wire logic xlExec,
    input wire logic xlSuper,
    output logic xlDone,
    output logic [30:0] xlPa,
    output logic xlCacheable,
    output logic [1:0] xlFault,
    input wire logic ioReq,
    input wire logic [30:0] ioAddr,
    input wire logic ioWe,
    input wire logic [31:0] ioWdata,
    output logic ioAck,
    input wire logic dcReq,
    input wire logic [30:0] dcAddr,
    input wire logic dcWe,
    input wire logic [31:0] dcWdata,
    output logic dcAck,
    output logic [31:0] busRdata,
    output logic memReq,
    output logic [30:0] memAddr,
    output logic memWe,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    localparam int N = tbmmu_pkg::TLB_ENTRIES;
    localparam int IW = tbmmu_pkg::IDX_W;
    localparam int PPN_HI = tbmmu_pkg::PTE_PPN_HI - tbmmu_pkg::PTF_LO;
    localparam int PPN_LO = tbmmu_pkg::PTE_PPN_LO - tbmmu_pkg::PTF_LO;
    localparam int CACHE_B = tbmmu_pkg::PTE_CACHE_BIT - tbmmu_pkg::PTF_LO;
    localparam int MOD_B = tbmmu_pkg::PTE_MOD_BIT - tbmmu_pkg::PTF_LO;

    // Tag bits 31:24, 23:18 and 17:12 are enabled by the three level bits
    function automatic logic [19:0] level_mask(input logic [2:0] lvl);
        level_mask = {{8{lvl[2]}}, {6{lvl[1]}}, {6{lvl[0]}}};
    endfunction

    function automatic logic entry_hit(input logic [2:0] lvl, input logic [19:0] tag,
        input logic [5:0] ctxTag, input logic sup, input logic [31:0] va,
        input logic [5:0] ctx, input logic superAcc);
        entry_hit = lvl[2] && (((tag ^ va[31:12]) & level_mask(lvl)) == 20'h0)
            && ((sup && superAcc) || (ctxTag == ctx));
    endfunction

    tbmmu_pkg::tbmmu_state_t state_reg;
    logic [5:0] context_reg;
    logic [30:0] ctp_reg;
    logic [2:0] faultStat_reg;
    logic [31:0] faultAddr_reg;
    logic [IW-1:0] tlbSel_reg;
    logic [IW-1:0] rr_reg;
    logic [31:0] va_reg;
    logic wr_reg;
    logic ex_reg;
    logic su_reg;
    logic [1:0] walkLvl_reg;
    logic walkReq_reg;
    logic walkWe_reg;
    logic [30:0] walkAddr_reg;
    logic [31:0] walkWdata_reg;
    logic walkAck_reg;
    logic [2:0] memSrc_reg;
    logic memDone_reg;

    logic [19:0] vtagArr [N];
    logic [5:0] ctxArr [N];
    logic [5:0] protArr [N];
    logic [2:0] lvlArr [N];
    logic supArr [N];
    logic modArr [N];
    logic ioNArr [N];
    logic ptpArr [N];
    logic [24:0] ptfArr [N];
    logic [30:0] pteAddrArr [N];

    logic [N-1:0] hitVec;
    logic anyHit;
    logic [IW-1:0] hitIdx;
    logic allowed;
    logic [19:0] hitMask;
    logic [30:0] hitPa;
    logic [1:0] walkEt;
    logic [30:0] walkNext;
    logic [2:0] fillLvl;
    logic fillEn;
    logic modSet;
    logic faultEv;
    logic [1:0] faultCode;
    logic apbAccess;
    logic apbWrite;
    logic mapped;
    logic [31:0] rdNext;

    tbmmu_arb_if arb ();

    tbmmu_arbiter u_arbiter
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .arb(arb)
    );

    generate
        for (genvar g = 0; g < N; g++)
        begin : g_cmp
            assign hitVec[g] = entry_hit(lvlArr[g], vtagArr[g], ctxArr[g], supArr[g],
                va_reg, context_reg, su_reg);
        end
    endgenerate

    always_comb
    begin
        hitIdx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (hitVec[i])
                hitIdx = IW'(i);
        end
    end

    assign anyHit = |hitVec;
    assign hitMask = level_mask(lvlArr[hitIdx]);
    // Unmatched page bits come from the virtual address, offset passes through
    assign hitPa = {(ptfArr[hitIdx][PPN_HI:PPN_LO] & hitMask[18:0])
        | (va_reg[30:12] & ~hitMask[18:0]), va_reg[11:0]};

    always_comb
    begin
        if (su_reg)
            allowed = wr_reg ? protArr[hitIdx][tbmmu_pkg::P_SW]
                : ex_reg ? protArr[hitIdx][tbmmu_pkg::P_SX]
                : protArr[hitIdx][tbmmu_pkg::P_SR];
        else
            allowed = wr_reg ? protArr[hitIdx][tbmmu_pkg::P_UW]
                : ex_reg ? protArr[hitIdx][tbmmu_pkg::P_UX]
                : protArr[hitIdx][tbmmu_pkg::P_UR];
    end

    assign walkEt = busRdata[1:0];
    always_comb
    begin
        case (walkLvl_reg)
            2'h0: walkNext = {busRdata[tbmmu_pkg::PTE_PTP_HI:tbmmu_pkg::PTE_PTP_LO],
                tbmmu_pkg::PTP_BASE_PAD} + {21'h0, va_reg[31:24], 2'h0};
            2'h1: walkNext = {busRdata[tbmmu_pkg::PTE_PTP_HI:tbmmu_pkg::PTE_PTP_LO],
                tbmmu_pkg::PTP_BASE_PAD} + {23'h0, va_reg[23:18], 2'h0};
            default: walkNext = {busRdata[tbmmu_pkg::PTE_PTP_HI:tbmmu_pkg::PTE_PTP_LO],
                tbmmu_pkg::PTP_BASE_PAD} + {23'h0, va_reg[17:12], 2'h0};
        endcase
        case (walkLvl_reg)
            2'h1: fillLvl = tbmmu_pkg::LVL_1;
            2'h2: fillLvl = tbmmu_pkg::LVL_2;
            2'h3: fillLvl = tbmmu_pkg::LVL_3;
            default: fillLvl = tbmmu_pkg::LVL_NONE;
        endcase
    end

    // A leaf in the context table would map all 4 GB; this design faults on it
    assign fillEn = (state_reg == tbmmu_pkg::XL_WALK) && walkAck_reg
        && (walkEt == tbmmu_pkg::ET_LEAF) && (walkLvl_reg != tbmmu_pkg::WALK_CTX);
    assign modSet = (state_reg == tbmmu_pkg::XL_LOOKUP) && anyHit && allowed && wr_reg
        && !modArr[hitIdx];

    always_comb
    begin
        faultEv = 1'b0;
        faultCode = tbmmu_pkg::FLT_NONE;
        if ((state_reg == tbmmu_pkg::XL_LOOKUP) && anyHit && !allowed)
        begin
            faultEv = 1'b1;
            faultCode = tbmmu_pkg::FLT_PROT;
        end
        else if ((state_reg == tbmmu_pkg::XL_WALK) && walkAck_reg && !fillEn)
        begin
            if (walkEt == tbmmu_pkg::ET_PTP)
            begin
                faultEv = (walkLvl_reg == tbmmu_pkg::WALK_LAST);
                faultCode = tbmmu_pkg::FLT_WALK;
            end
            else
            begin
                faultEv = 1'b1;
                faultCode = tbmmu_pkg::FLT_INVALID;
            end
        end
    end

    // Valid bits carry reset; flush wins over a fill in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < N; i++)
                lvlArr[i] <= tbmmu_pkg::LVL_NONE;
            rr_reg <= '0;
        end
        else if (apbWrite && (paddr == tbmmu_pkg::REG_FLUSH))
        begin
            for (int i = 0; i < N; i++)
                lvlArr[i] <= tbmmu_pkg::LVL_NONE;
        end
        else if (fillEn)
        begin
            lvlArr[rr_reg] <= fillLvl;
            rr_reg <= rr_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (fillEn)
        begin
            vtagArr[rr_reg] <= va_reg[31:12];
            ctxArr[rr_reg] <= context_reg;
            protArr[rr_reg] <= tbmmu_pkg::decode_acc(
                busRdata[tbmmu_pkg::PTE_ACC_HI:tbmmu_pkg::PTE_ACC_LO]);
            supArr[rr_reg] <= (busRdata[tbmmu_pkg::PTE_ACC_HI:tbmmu_pkg::PTE_MOD_BIT - 3]
                == 2'h3);
            modArr[rr_reg] <= busRdata[tbmmu_pkg::PTE_MOD_BIT];
            ioNArr[rr_reg] <= 1'b1;
            ptpArr[rr_reg] <= 1'b0;
            ptfArr[rr_reg] <= busRdata[tbmmu_pkg::PTE_PPN_HI:tbmmu_pkg::PTF_LO];
            pteAddrArr[rr_reg] <= walkAddr_reg;
        end
        else if (modSet)
        begin
            modArr[hitIdx] <= 1'b1;
            ptfArr[hitIdx][MOD_B] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= tbmmu_pkg::XL_IDLE;
            va_reg <= '0;
            wr_reg <= 1'b0;
            ex_reg <= 1'b0;
            su_reg <= 1'b0;
            walkLvl_reg <= tbmmu_pkg::WALK_CTX;
            walkReq_reg <= 1'b0;
            walkWe_reg <= 1'b0;
            walkAddr_reg <= '0;
            walkWdata_reg <= '0;
            xlDone <= 1'b0;
            xlPa <= '0;
            xlCacheable <= 1'b0;
            xlFault <= tbmmu_pkg::FLT_NONE;
        end
        else
        begin
            xlDone <= 1'b0;
            if (walkAck_reg)
                walkReq_reg <= 1'b0;
            if (faultEv)
            begin
                xlDone <= 1'b1;
                xlFault <= faultCode;
                xlCacheable <= 1'b0;
                state_reg <= tbmmu_pkg::XL_IDLE;
            end
            else
            begin
                case (state_reg)
                    tbmmu_pkg::XL_IDLE:
                        if (xlReq && !xlDone)
                        begin
                            va_reg <= xlVa;
                            wr_reg <= xlWrite;
                            ex_reg <= xlExec;
                            su_reg <= xlSuper;
                            state_reg <= tbmmu_pkg::XL_LOOKUP;
                        end
                    tbmmu_pkg::XL_LOOKUP:
                        if (!anyHit)
                        begin
                            walkLvl_reg <= tbmmu_pkg::WALK_CTX;
                            walkAddr_reg <= ctp_reg + {23'h0, context_reg, 2'h0};
                            walkWe_reg <= 1'b0;
                            walkReq_reg <= 1'b1;
                            state_reg <= tbmmu_pkg::XL_WALK;
                        end
                        else if (modSet)
                        begin
                            walkAddr_reg <= pteAddrArr[hitIdx];
                            walkWdata_reg <= {5'h0, ptfArr[hitIdx], tbmmu_pkg::ET_LEAF}
                                | (32'h1 << tbmmu_pkg::PTE_MOD_BIT)
                                | (32'h1 << tbmmu_pkg::PTE_REF_BIT);
                            walkWe_reg <= 1'b1;
                            walkReq_reg <= 1'b1;
                            state_reg <= tbmmu_pkg::XL_UPDATE;
                        end
                        else
                        begin
                            xlDone <= 1'b1;
                            xlFault <= tbmmu_pkg::FLT_NONE;
                            xlPa <= hitPa;
                            xlCacheable <= ptfArr[hitIdx][CACHE_B];
                            state_reg <= tbmmu_pkg::XL_IDLE;
                        end
                    tbmmu_pkg::XL_WALK:
                        if (walkAck_reg)
                        begin
                            if (fillEn)
                            begin
                                walkWdata_reg <= busRdata
                                    | (32'h1 << tbmmu_pkg::PTE_REF_BIT);
                                walkWe_reg <= 1'b1;
                                walkReq_reg <= 1'b1;
                                state_reg <= tbmmu_pkg::XL_UPDATE;
                            end
                            else
                            begin
                                walkLvl_reg <= walkLvl_reg + 1'b1;
                                walkAddr_reg <= walkNext;
                                walkReq_reg <= 1'b1;
                            end
                        end
                    tbmmu_pkg::XL_UPDATE:
                        if (walkAck_reg)
                            state_reg <= tbmmu_pkg::XL_LOOKUP;
                    default:
                        state_reg <= tbmmu_pkg::XL_IDLE;
                endcase
            end
        end
    end

    assign arb.req = {ioReq, dcReq, walkReq_reg};
    assign arb.done = memDone_reg;

    // The done cycle blocks a reload while the arbiter still shows the old grant
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            memReq <= 1'b0;
            memAddr <= '0;
            memWe <= 1'b0;
            memWdata <= '0;
            memSrc_reg <= '0;
            memDone_reg <= 1'b0;
            busRdata <= '0;
            ioAck <= 1'b0;
            dcAck <= 1'b0;
            walkAck_reg <= 1'b0;
        end
        else
        begin
            memDone_reg <= 1'b0;
            ioAck <= 1'b0;
            dcAck <= 1'b0;
            walkAck_reg <= 1'b0;
            if (memReq)
            begin
                if (memAck)
                begin
                    memReq <= 1'b0;
                    memDone_reg <= 1'b1;
                    busRdata <= memRdata;
                    ioAck <= memSrc_reg[tbmmu_pkg::SRC_IO];
                    dcAck <= memSrc_reg[tbmmu_pkg::SRC_DC];
                    walkAck_reg <= memSrc_reg[tbmmu_pkg::SRC_WALK];
                end
            end
            else if (!memDone_reg && (arb.gnt != '0))
            begin
                memReq <= 1'b1;
                memSrc_reg <= arb.gnt;
                memAddr <= arb.gnt[tbmmu_pkg::SRC_WALK] ? walkAddr_reg
                    : arb.gnt[tbmmu_pkg::SRC_DC] ? dcAddr : ioAddr;
                memWe <= arb.gnt[tbmmu_pkg::SRC_WALK] ? walkWe_reg
                    : arb.gnt[tbmmu_pkg::SRC_DC] ? dcWe : ioWe;
                memWdata <= arb.gnt[tbmmu_pkg::SRC_WALK] ? walkWdata_reg
                    : arb.gnt[tbmmu_pkg::SRC_DC] ? dcWdata : ioWdata;
            end
        end
    end

    assign apbAccess = psel && penable && !pready;
    assign apbWrite = psel && penable && pready && pwrite && mapped;
    assign mapped = (paddr == tbmmu_pkg::REG_CONTEXT) || (paddr == tbmmu_pkg::REG_CTP)
        || (paddr == tbmmu_pkg::REG_FAULT_STAT) || (paddr == tbmmu_pkg::REG_FAULT_ADDR)
        || (paddr == tbmmu_pkg::REG_TLB_SEL) || (paddr == tbmmu_pkg::REG_TLB_PTF)
        || (paddr == tbmmu_pkg::REG_FLUSH);

    always_comb
    begin
        case (paddr)
            tbmmu_pkg::REG_CONTEXT: rdNext = {26'h0, context_reg};
            tbmmu_pkg::REG_CTP: rdNext = {1'b0, ctp_reg};
            tbmmu_pkg::REG_FAULT_STAT: rdNext = {23'h0, faultStat_reg[2], 6'h0,
                faultStat_reg[1:0]};
            tbmmu_pkg::REG_FAULT_ADDR: rdNext = faultAddr_reg;
            tbmmu_pkg::REG_TLB_SEL: rdNext = {{(32 - IW){1'b0}}, tlbSel_reg};
            tbmmu_pkg::REG_TLB_PTF: rdNext = {7'h0, ptfArr[tlbSel_reg]};
            default: rdNext = 32'h0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= apbAccess;
            pslverr <= apbAccess && !mapped;
            if (apbAccess)
                prdata <= (mapped && !pwrite) ? rdNext : 32'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            context_reg <= '0;
            ctp_reg <= '0;
            tlbSel_reg <= '0;
        end
        else if (apbWrite)
        begin
            if (paddr == tbmmu_pkg::REG_CONTEXT)
                context_reg <= pwdata[5:0];
            if (paddr == tbmmu_pkg::REG_CTP)
                ctp_reg <= {pwdata[30:2], 2'h0};
            if (paddr == tbmmu_pkg::REG_TLB_SEL)
                tlbSel_reg <= pwdata[IW-1:0];
        end
    end

    // A new fault wins over a clear written in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            faultStat_reg <= '0;
            faultAddr_reg <= '0;
        end
        else if (faultEv)
        begin
            faultStat_reg <= {1'b1, faultCode};
            faultAddr_reg <= va_reg;
        end
        else if (apbWrite && (paddr == tbmmu_pkg::REG_FAULT_STAT)
            && pwdata[tbmmu_pkg::FAULT_VALID_BIT])
            faultStat_reg <= '0;
    end
endmodule
`default_nettype wire

// *** dv/tbmmu_checker.sv ***
`default_nettype none
module tbmmu_checker (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic xlReq,
    input wire logic [31:0] xlVa,
    input wire logic xlDone,
    input wire logic [30:0] xlPa,
    input wire logic [1:0] xlFault,
    input wire logic memReq,
    input wire logic [30:0] memAddr,
    input wire logic memAck,
    input wire logic ioAck,
    input wire logic dcAck
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence apbStart;
        psel && penable && !$past(penable);
    endsequence
    sequence oneWait;
        !pready ##1 pready;
    endsequence
    apb_wait_a: assert property (apbStart |-> oneWait) else $error("wait state");
    slverr_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
    done_pulse_a: assert property (xlDone |=> !xlDone) else $error("long done");
    done_req_a: assert property (xlDone |-> xlReq) else $error("stray done");
    offset_pass_a: assert property (xlDone && xlFault == 2'h0 |-> xlPa[11:0] == xlVa[11:0])
        else $error("offset changed");
    mem_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("request moved");
    mem_gap_a: assert property (memReq && memAck |=> !memReq) else $error("no gap");
    ack_source_a: assert property (ioAck || dcAck |-> $past(memAck) && !(ioAck && dcAck))
        else $error("ack without memory");
endmodule
`default_nettype wire

// *** dv/tbmmu_mem_model.sv ***
`default_nettype none
module tbmmu_mem_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic memReq,
    input wire logic [30:0] memAddr,
    input wire logic memWe,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic [31:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [int];
    int slow = 0;
    int lag = 0;
    always @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            memAck <= 1'b0;
        else if (memAck)
            // Released data flips so a late sample never matches
            {memAck, memRdata} <= {1'b0, ~memRdata};
        else if (memReq && lag < slow)
            lag <= lag + 1;
        else if (memReq)
        begin
            lag <= 0;
            memAck <= 1'b1;
            if (memWe)
                mem[memAddr] = memWdata;
            memRdata <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
        end
endmodule
`default_nettype wire

// *** dv/tb_translation_buffer_mmu.sv ***
`default_nettype none
module tb_translation_buffer_mmu;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, xlReq = 0, xlWrite = 0;
    logic xlExec = 0, xlSuper = 0, ioReq = 0, ioWe = 0, dcReq = 0, dcWe = 0;
    logic pready, pslverr, xlDone, xlCacheable, ioAck, dcAck, memReq, memWe, memAck, err;
    logic [7:0] paddr = 0;
    logic [30:0] ioAddr = 0, dcAddr = 0, xlPa, memAddr;
    logic [31:0] pwdata = 0, xlVa = 0, ioWdata = 0, dcWdata = 0, prdata, busRdata, memWdata;
    logic [31:0] memRdata, rd, wd, vaM [8], leafA [8], leafM [8];
    logic [1:0] xlFault, f;
    int nFail = 0, cmpCount = 0, cyc = 0, seed = 28226;
    localparam logic [5:0] PERM [8] = '{6'h24, 6'h36, 6'h2d, 6'h3f, 6'h09, 6'h21, 6'h05, 6'h07};
    always #5 sys_clk = ~sys_clk;
    tbmmu_core dut (.sys_clk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .xlReq, .xlVa, .xlWrite, .xlExec, .xlSuper, .xlDone, .xlPa,
        .xlCacheable, .xlFault, .ioReq, .ioAddr, .ioWe, .ioWdata, .ioAck, .dcReq, .dcAddr,
        .dcWe, .dcWdata, .dcAck, .busRdata, .memReq, .memAddr, .memWe, .memWdata, .memAck,
        .memRdata);
    tbmmu_mem_model mdl (.sys_clk, .arst_n, .memReq, .memAddr, .memWe, .memWdata, .memAck,
        .memRdata);
    always @(posedge sys_clk)
        if (++cyc == 20000)
        begin
            nFail++;
            tally_and_finish();
        end
    task automatic chk(input logic [31:0] got, exp);
        cmpCount++;
        if (got !== exp)
        begin
            nFail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tally_and_finish();
        $display("mismatches %0d compares %0d", nFail, cmpCount);
        if (nFail == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk) penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b0;
    endtask
    task xl(input logic [31:0] va, input logic w, x, s);
        @(posedge sys_clk) {xlReq, xlVa, xlWrite, xlExec, xlSuper} <= {1'b1, va, w, x, s};
        do @(posedge sys_clk); while (xlDone !== 1'b1);
        xlReq <= 1'b0;
    endtask
    task mbus(input logic io, input logic [30:0] a, input logic we);
        wd = $random(seed);
        if (!we)
            mdl.mem[a] = wd;
        @(posedge sys_clk) {ioReq, dcReq, ioAddr, dcAddr, ioWe, dcWe, ioWdata, dcWdata} <=
            {io, !io, a, a, we, we, wd, wd};
        do @(posedge sys_clk); while (ioAck !== 1'b1 && dcAck !== 1'b1);
        {ioReq, dcReq} <= 2'b0;
        chk(we ? mdl.mem[a] : busRdata, wd);
    endtask
    task run(input int p);
        logic w, x, s;
        for (int i = 0; i < 8; i++)
        begin
            {w, x, s} = p < 2 ? 3'($random(seed)) : 3'b001;
            f = PERM[i][(s ? 0 : 3) + (w ? 1 : x ? 0 : 2)] ? 2'h0 : 2'h1;
            if (p == 3 || p == 2 && i < 6)
                f = 2'h2;
            xl(vaM[i], w, x, s);
            chk(xlFault, f);
            if (f == 2'h0)
                chk({xlPa, xlCacheable}, {leafM[i][26:8], vaM[i][11:0], leafM[i][7]});
            if (f == 2'h0 && w)
                leafM[i][6] = 1'b1;
            if (p < 2)
                chk(mdl.mem[leafA[i]], leafM[i]);
        end
        $display("pass %0d done", p);
    endtask
    initial
    begin
        mdl.mem[32'h1014] = 32'h201;
        for (int i = 0; i < 8; i++)
        begin
            vaM[i] = {8'(i + 1), 24'($random(seed))};
            mdl.mem[32'h2004 + i * 4] = (32'h3000 + i * 256) >> 4 | 1;
            mdl.mem[32'h3000 + i * 256 + vaM[i][23:18] * 4] = (32'h8000 + i * 256) >> 4 | 1;
            leafA[i] = 32'h8000 + i * 256 + vaM[i][17:12] * 4;
            leafM[i] = {5'h0, 19'($random(seed)), 1'(i), 2'h0, 3'(i), 2'h2};
            mdl.mem[leafA[i]] = leafM[i];
            leafM[i][5] = 1'b1;
        end
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(8'h04, 1'b1, 32'h1000);
        apb(8'h00, 1'b1, 32'h5);
        apb(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h5);
        apb(8'h1c, 1'b0, 32'h0);
        chk(err, 32'h1);
        mdl.slow = 2;
        fork
            run(0);
            mbus(1'b0, 31'h5000, 1'b0);
        join
        mbus(1'b1, 31'h6000, 1'b1);
        run(1);
        apb(8'h14, 1'b0, 32'h0);
        chk({rd[24:4], rd[2:0]}, {leafM[0][26:6], leafM[0][4:2]});
        mdl.slow = 0;
        apb(8'h00, 1'b1, 32'h6);
        run(2);
        apb(8'h18, 1'b1, 32'h0);
        run(3);
        apb(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h102);
        tally_and_finish();
    end
endmodule
bind tbmmu_core tbmmu_checker chk_i (.sys_clk, .arst_n, .psel, .penable, .pready, .pslverr,
    .xlReq, .xlVa, .xlDone, .xlPa, .xlFault, .memReq, .memAddr, .memAck, .ioAck, .dcAck);
`default_nettype wire
